// [pgcs_map.svh]
`ifndef PGCS_MAP_SVH
`define PGCS_MAP_SVH
// pll-free timing: system clock 200 MHz
`define PGCS_CLK_HZ          200000000
`define PGCS_FAST_OSC_HZ     1000000
`define PGCS_SLOW_OSC_HZ     500000
`define PGCS_SYNC_MIN_HZ     100000
`define PGCS_SYNC_MAX_HZ     5000000
// half periods in system cycles
`define PGCS_FAST_HALF       (`PGCS_CLK_HZ / (2 * `PGCS_FAST_OSC_HZ))
`define PGCS_SLOW_HALF       (`PGCS_CLK_HZ / (2 * `PGCS_SLOW_OSC_HZ))
// sync loss timeout: one slowest legal sync period, rounded up
`define PGCS_SYNC_TIMEOUT    ((`PGCS_CLK_HZ + `PGCS_SYNC_MIN_HZ - 1) / `PGCS_SYNC_MIN_HZ)
// edges seen before sync is trusted
`define PGCS_SYNC_EDGES      3
// power ok qualify count in reference cycles
`define PGCS_OK_COUNT        64
// register offsets and interrupt bit positions
`define PGCS_ADDR_STATUS     8'h00
`define PGCS_ADDR_MASK       8'h04
`define PGCS_ADDR_STATE      8'h08
`define PGCS_BIT_OK_RISE     0
`define PGCS_BIT_OK_FALL     1
`define PGCS_BIT_SYNC_CHG    2
`define PGCS_BIT_ENABLE_CHG  3
`define PGCS_NUM_EVENTS      4
`define PGCS_MASK_RESET      4'h0
`endif

// [pgcs_pkg.sv]
package pgcs_pkg;
  // wishbone request from master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pgcs_wb_req_t;

  // wishbone answer to master
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } pgcs_wb_rsp_t;

  // qualifier phase
  typedef enum logic [1:0] {
    PGCS_OFF      = 2'b00,
    PGCS_QUALIFY  = 2'b01,
    PGCS_GOOD     = 2'b10,
    PGCS_DISQUAL  = 2'b11
  } pgcs_ok_state_t;

  // reference clock source
  typedef enum logic [0:0] {
    PGCS_SRC_INT  = 1'b0,
    PGCS_SRC_EXT  = 1'b1
  } pgcs_src_t;

  // pin side outputs
  typedef struct packed {
    logic power_ok_flag_oe;
    logic inverted_clock_out_oe;
    logic softstart_node_oe;
    logic switch_out_en;
    logic high_side_on;
    logic enabled;
  } pgcs_pins_t;
endpackage

// [pgcs_ok_qual.sv]
`timescale 1ns/1ps
`include "pgcs_map.svh"
// window qualifier: counts reference ticks while window state disagrees with flag
module pgcs_ok_qual #(
  parameter int COUNT = `PGCS_OK_COUNT
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // controls
  input  wire logic hold_i,
  input  wire logic tick_i,
  input  wire logic in_window_i,
  // result
  output logic      ok_o,
  output pgcs_pkg::pgcs_ok_state_t state_o
);
  import pgcs_pkg::*;

  typedef struct packed {
    pgcs_ok_state_t st;
    logic [7:0]     cnt;
    logic           ok;
  } pgcs_qual_state_t;

  pgcs_qual_state_t s_r;
  pgcs_qual_state_t s_nxt;

  localparam logic [7:0] LAST = 8'(COUNT - 1);

  // next state of the one counter shared by rise and fall
  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      PGCS_OFF:
      begin
        s_nxt.cnt = 8'h00;
        s_nxt.ok  = 1'b0;
        if (in_window_i)
          s_nxt.st = PGCS_QUALIFY;
      end
      PGCS_QUALIFY:
      begin
        if (!in_window_i)
        begin
          s_nxt.cnt = 8'h00;
          s_nxt.st  = PGCS_OFF;
        end
        else if (tick_i)
        begin
          if (s_r.cnt == LAST)
          begin
            s_nxt.ok  = 1'b1;
            s_nxt.cnt = 8'h00;
            s_nxt.st  = PGCS_GOOD;
          end
          else
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
      end
      PGCS_GOOD:
      begin
        s_nxt.cnt = 8'h00;
        if (!in_window_i)
          s_nxt.st = PGCS_DISQUAL;
      end
      PGCS_DISQUAL:
      begin
        if (in_window_i)
        begin
          s_nxt.cnt = 8'h00;
          s_nxt.st  = PGCS_GOOD;
        end
        else if (tick_i)
        begin
          if (s_r.cnt == LAST)
          begin
            s_nxt.ok  = 1'b0;
            s_nxt.cnt = 8'h00;
            s_nxt.st  = PGCS_OFF;
          end
          else
            s_nxt.cnt = s_r.cnt + 8'h01;
        end
      end
      default:
      begin
        s_nxt.st = PGCS_OFF;
      end
    endcase
    if (hold_i)
    begin
      s_nxt.st  = PGCS_OFF;
      s_nxt.cnt = 8'h00;
      s_nxt.ok  = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r.st  <= PGCS_OFF;
      s_r.cnt <= 8'h00;
      s_r.ok  <= 1'b0;
    end
    else
      s_r <= s_nxt;
  end

  assign ok_o    = s_r.ok;
  assign state_o = s_r.st;
endmodule

// [pgcs_top.sv]
// Design decisions made here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "pgcs_map.svh"
module pgcs_top #(
  parameter int SYNC_TIMEOUT = `PGCS_SYNC_TIMEOUT,
  parameter int FAST_HALF    = `PGCS_FAST_HALF,
  parameter int SLOW_HALF    = `PGCS_SLOW_HALF
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // wishbone slave
  input  pgcs_pkg::pgcs_wb_req_t    wb_req_i,
  output pgcs_pkg::pgcs_wb_rsp_t    wb_rsp_o,
  // analog comparator flags and pins
  input  wire logic                 window_ok_i,
  input  wire logic                 lockout_clear_i,
  input  wire logic                 shutdown_n_input_i,
  input  wire logic                 sync_strap_i,
  // outputs
  output pgcs_pkg::pgcs_pins_t      pins_o,
  output logic                      power_ok_flag_o,
  output logic                      ref_clk_o,
  output logic                      irq_o
);
  import pgcs_pkg::*;

  localparam int NE = `PGCS_NUM_EVENTS;

  typedef struct packed {
    logic [1:0]  win_s;
    logic [1:0]  lock_s;
    logic [1:0]  sdn_s;
    logic [1:0]  sync_s;
    logic        sync_d;
    logic [27:0] sync_tmo;
    logic [1:0]  sync_edges;
    pgcs_src_t   src;
    logic [15:0] osc_cnt;
    logic        osc;
    logic        ref_clk;
    logic        enabled;
    logic        ok_d;
    logic [NE-1:0] status;
    logic [NE-1:0] mask;
    logic        irq;
    pgcs_pins_t  pins;
    pgcs_wb_rsp_t rsp;
  } pgcs_top_state_t;

  pgcs_top_state_t s_r;
  pgcs_top_state_t s_nxt;

  logic           ok_q;
  logic           hold;
  logic           tick;
  logic           sync_rise;
  logic [15:0]    half;
  logic [NE-1:0]  evt;
  logic [NE-1:0]  clr;
  logic           wb_hit;
  logic [31:0]    rd;
  pgcs_ok_state_t ok_state;

  // enable gating and reference tick
  assign hold      = !(s_r.lock_s[1] && s_r.sdn_s[1]);
  assign sync_rise = s_r.sync_s[1] && !s_r.sync_d;
  assign half      = sync_strap_level() ? 16'(FAST_HALF) : 16'(SLOW_HALF);
  // tick on reference rising edge; the rising edge counts window cycles
  assign tick      = s_nxt.ref_clk && !s_r.ref_clk;

  // strap level for oscillator choice, already synchronised
  function automatic logic sync_strap_level();
    return s_r.sync_s[1];
  endfunction

  // power ok qualifier on reference ticks; window flag from comparator
  pgcs_ok_qual #(
    .COUNT (`PGCS_OK_COUNT)
  ) u_qual (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .hold_i      (hold),
    .tick_i      (tick),
    .in_window_i (s_r.win_s[1]),
    .ok_o        (ok_q),
    .state_o     (ok_state)
  );

  // bus hit and read mux
  assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !s_r.rsp.ack;
  always_comb
  begin
    rd = 32'h0000_0000;
    case (wb_req_i.adr)
      `PGCS_ADDR_STATUS: rd = {{(32-NE){1'b0}}, s_r.status};
      `PGCS_ADDR_MASK:   rd = {{(32-NE){1'b0}}, s_r.mask};
      `PGCS_ADDR_STATE:  rd = {26'h0, ok_state, s_r.src, s_r.enabled, ok_q, s_r.ref_clk};
      default:           rd = 32'h0000_0000;
    endcase
  end

  // write-one clears of the status bits
  assign clr = (wb_hit && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == `PGCS_ADDR_STATUS)
             ? wb_req_i.dat[NE-1:0] : {NE{1'b0}};

  // next state of everything
  always_comb
  begin
    s_nxt = s_r;
    // pin synchronisers, first stage read only by second
    s_nxt.win_s  = {s_r.win_s[0], window_ok_i};
    s_nxt.lock_s = {s_r.lock_s[0], lockout_clear_i};
    s_nxt.sdn_s  = {s_r.sdn_s[0], shutdown_n_input_i};
    s_nxt.sync_s = {s_r.sync_s[0], sync_strap_i};
    s_nxt.sync_d = s_r.sync_s[1];
    // sync activity detector
    if (sync_rise)
    begin
      s_nxt.sync_tmo = 28'h0;
      if (s_r.sync_edges != 2'(`PGCS_SYNC_EDGES))
        s_nxt.sync_edges = s_r.sync_edges + 2'h1;
    end
    else if (s_r.sync_tmo >= 28'(SYNC_TIMEOUT))
    begin
      s_nxt.sync_edges = 2'h0;
    end
    else
      s_nxt.sync_tmo = s_r.sync_tmo + 28'h1;
    s_nxt.src = (s_nxt.sync_edges == 2'(`PGCS_SYNC_EDGES)) ? PGCS_SRC_EXT : PGCS_SRC_INT;
    // internal oscillator divider
    if (s_r.osc_cnt >= half - 16'h1)
    begin
      s_nxt.osc_cnt = 16'h0;
      s_nxt.osc     = !s_r.osc;
    end
    else
      s_nxt.osc_cnt = s_r.osc_cnt + 16'h1;
    // reference selection
    s_nxt.ref_clk = (s_r.src == PGCS_SRC_EXT) ? s_r.sync_s[1] : s_r.osc;
    // enable and pin drive
    s_nxt.enabled                    = !hold;
    s_nxt.pins.enabled               = !hold;
    s_nxt.pins.switch_out_en         = s_r.sdn_s[1];
    s_nxt.pins.softstart_node_oe     = !s_r.sdn_s[1];
    // open drain low while reference high, giving the complement
    s_nxt.pins.inverted_clock_out_oe = s_nxt.ref_clk;
    s_nxt.pins.high_side_on          = !hold && s_r.ref_clk && !s_nxt.ref_clk;
    s_nxt.pins.power_ok_flag_oe      = !ok_q;
    s_nxt.ok_d                       = ok_q;
    // event sources, taken once the next clock source is known
    evt[`PGCS_BIT_OK_RISE]    = ok_q && !s_r.ok_d;
    evt[`PGCS_BIT_OK_FALL]    = !ok_q && s_r.ok_d;
    evt[`PGCS_BIT_SYNC_CHG]   = s_nxt.src != s_r.src;
    evt[`PGCS_BIT_ENABLE_CHG] = (!hold) != s_r.enabled;
    // sticky status, set wins over clear
    s_nxt.status = (s_r.status & ~clr) | evt;
    if (wb_hit && wb_req_i.we && wb_req_i.sel[0] && wb_req_i.adr == `PGCS_ADDR_MASK)
      s_nxt.mask = wb_req_i.dat[NE-1:0];
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);
    // wishbone answer, one cycle after request
    s_nxt.rsp.ack = wb_hit;
    s_nxt.rsp.dat = wb_hit ? rd : 32'h0000_0000;
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r      <= '0;
      s_r.mask <= `PGCS_MASK_RESET;
      // flag pin pulled low while in reset, ok is not yet qualified
      s_r.pins.power_ok_flag_oe <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  // outputs
  assign wb_rsp_o        = s_r.rsp;
  assign pins_o          = s_r.pins;
  assign power_ok_flag_o = s_r.ok_d;
  assign ref_clk_o       = s_r.ref_clk;
  assign irq_o           = s_r.irq;
endmodule

// [pgcs_board.sv]
`timescale 1ns/1ps
module pgcs_board (
  // clock
  input  wire logic       clk_i,
  // sync pin control
  input  wire logic       run_i,
  input  wire logic       strap_i,
  input  wire logic [7:0] half_i,
  output logic            sync_o
);
  logic [7:0] cnt_r = 8'h00;
  logic       tgl_r = 1'b0;
  wire        wrap = cnt_r >= half_i - 8'h01;
  // pulse train, half_i kept in 20..40 for a legal rate
  always @(posedge clk_i)
  begin
    cnt_r <= (!run_i || wrap) ? 8'h00 : cnt_r + 8'h01;
    tgl_r <= run_i && (wrap ? ~tgl_r : tgl_r);
  end
  // train while running, else static strap level
  assign sync_o = run_i ? tgl_r : strap_i;
endmodule

// [pgcs_top_properties.sv]
`timescale 1ns/1ps
module pgcs_props #(
  parameter int SYNC_TIMEOUT = 100,
  parameter int FAST_HALF    = 4,
  parameter int SLOW_HALF    = 8
) (
  // clock, reset, bus
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  pgcs_pkg::pgcs_wb_req_t wb_req_i,
  input  pgcs_pkg::pgcs_wb_rsp_t wb_rsp_o,
  // pins
  input  wire logic             window_ok_i,
  input  wire logic             lockout_clear_i,
  input  wire logic             shutdown_n_input_i,
  input  wire logic             sync_strap_i,
  input  pgcs_pkg::pgcs_pins_t  pins_o,
  input  wire logic             power_ok_flag_o,
  input  wire logic             ref_clk_o,
  input  wire logic             irq_o
);
  import pgcs_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       ref_q;
  logic [6:0] in_e;
  logic [6:0] out_e;
  logic [3:0] calm;
  wire        up = ref_clk_o && !ref_q;
  wire        hold = !(shutdown_n_input_i && lockout_clear_i);
  // reference rises per window phase, cycles since hold
  always_ff @(posedge clk_i)
  begin
    ref_q <= ref_clk_o;
    in_e  <= (rst_i || !window_ok_i) ? 7'h00 : in_e + {6'h00, up && in_e != 7'h7f};
    out_e <= (rst_i || window_ok_i) ? 7'h00 : out_e + {6'h00, up && out_e != 7'h7f};
    calm  <= (rst_i || hold) ? 4'h0 : calm + {3'h0, calm != 4'hf};
  end
  inv_clk_a: assert property (pins_o.inverted_clock_out_oe == ref_clk_o)
    else $error("inverted clock not following reference");
  sd_drain_a: assert property (!shutdown_n_input_i [*5] |-> pins_o.softstart_node_oe)
    else $error("soft start not discharged");
  sd_tristate_a: assert property (!shutdown_n_input_i [*5] |-> !pins_o.switch_out_en)
    else $error("switch output driven in shutdown");
  enable_gate_a: assert property (hold [*5] |-> !pins_o.enabled)
    else $error("enabled while held");
  ok_hold_a: assert property (hold [*6] |-> !power_ok_flag_o)
    else $error("power ok while held");
  ok_rise_a: assert property ($rose(power_ok_flag_o) |-> in_e >= 7'h3e)
    else $error("power ok rose early");
  ok_fall_a: assert property ($fell(power_ok_flag_o) && calm == 4'hf |-> out_e >= 7'h3e)
    else $error("power ok fell early");
  high_side_a: assert property ($fell(ref_clk_o) && pins_o.enabled |-> ##[0:2] pins_o.high_side_on)
    else $error("no high side pulse");
  ack_pulse_a: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
    else $error("ack longer than one cycle");
  ok_pin_a: assert property (pins_o.power_ok_flag_oe == !power_ok_flag_o)
    else $error("power ok pin drive not complement of flag");
  cover property ($rose(power_ok_flag_o));
  cover property ($fell(power_ok_flag_o));
  cover property ($rose(irq_o));
endmodule
bind pgcs_top pgcs_props #(
  .SYNC_TIMEOUT(SYNC_TIMEOUT),
  .FAST_HALF   (FAST_HALF),
  .SLOW_HALF   (SLOW_HALF)
) u_props (
  .clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .window_ok_i, .lockout_clear_i,
  .shutdown_n_input_i, .sync_strap_i, .pins_o, .power_ok_flag_o, .ref_clk_o, .irq_o
);

// [pgcs_top_tb.sv]
`timescale 1ns/1ps
module pgcs_top_tb;
  import pgcs_pkg::*;
  localparam int FH = 4;
  localparam int SH = 8;
  logic         clk_i = 1'b0;
  logic         rst_i;
  pgcs_wb_req_t wb_req_i;
  pgcs_wb_rsp_t wb_rsp_o;
  logic         window_ok_i;
  logic         lockout_clear_i;
  logic         shutdown_n_input_i;
  logic         sync_strap_i;
  pgcs_pins_t   pins_o;
  logic         power_ok_flag_o;
  logic         ref_clk_o;
  logic         irq_o;
  logic         run;
  logic         strap;
  logic [7:0]   half;
  logic         rq;
  int           err_total = 0;
  int           n_checks = 0;
  logic [31:0]  expq[$];
  pgcs_top #(
    .SYNC_TIMEOUT(100),
    .FAST_HALF   (FH),
    .SLOW_HALF   (SH)
  ) uut (
    .clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .window_ok_i, .lockout_clear_i,
    .shutdown_n_input_i, .sync_strap_i, .pins_o, .power_ok_flag_o, .ref_clk_o, .irq_o
  );
  pgcs_board u_board (.clk_i, .run_i(run), .strap_i(strap), .half_i(half), .sync_o(sync_strap_i));
  // clock and reference edge history
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) rq <= ref_clk_o;
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // read answers against oldest note
  always @(posedge clk_i)
    if (wb_rsp_o.ack === 1'b1 && !wb_req_i.we && expq.size() > 0)
      check("rdata", wb_rsp_o.dat, expq.pop_front());
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    wb_req_i <= '{1'b1, 1'b1, w, a, 4'hf, d};
    if (!w)
      expq.push_back(e);
    do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1);
    wb_req_i <= '0;
    @(posedge clk_i);
  endtask
  // reference rises until flag reaches lvl
  task automatic rises(input logic lvl, output int n);
    n = 0;
    while (power_ok_flag_o !== lvl)
    begin
      @(posedge clk_i);
      n += int'(ref_clk_o && !rq);
    end
  endtask
  // high time of reference in clocks
  task automatic meas(output int h);
    h = 0;
    do @(posedge clk_i); while (!(ref_clk_o && !rq));
    do
    begin
      @(posedge clk_i);
      h++;
    end while (ref_clk_o === 1'b1);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wait_n(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  // main sequence
  initial
  begin
    int n;
    void'($urandom(6));
    {rst_i, window_ok_i, lockout_clear_i, shutdown_n_input_i, run, strap} = 6'b100001;
    wb_req_i = '0;
    half = 8'h14;
    wait_n(2);
    rst_i <= 1'b0;
    wait_n(1);
    wb(1'b0, 8'h04, 32'h0, 32'h0);
    wb(1'b0, 8'h20, 32'h0, 32'h0);
    wb(1'b1, 8'h20, 32'hff, 32'h0);
    wb(1'b1, 8'h04, 32'h1, 32'h0);
    wb(1'b0, 8'h04, 32'h0, 32'h1);
    shutdown_n_input_i <= 1'b1;
    wait_n(8);
    check("lockout", pins_o.enabled, 32'h0);
    lockout_clear_i <= 1'b1;
    wait_n(8);
    check("enable", pins_o.enabled, 32'h1);
    meas(n);
    check("fast half", n, FH);
    $display("test startup done");
    window_ok_i <= 1'b1;
    wait_n($urandom_range(300, 50));
    check("early ok", power_ok_flag_o, 32'h0);
    window_ok_i <= 1'b0;
    wait_n(1);
    window_ok_i <= 1'b1;
    rises(1'b1, n);
    check("rise count", n inside {[64:65]}, 32'h1);
    wait_n(3);
    check("irq set", irq_o, 32'h1);
    wb(1'b1, 8'h04, 32'h0, 32'h0);
    wait_n(3);
    check("irq masked", irq_o, 32'h0);
    wb(1'b1, 8'h00, 32'hf, 32'h0);
    wb(1'b1, 8'h04, 32'h1, 32'h0);
    wb(1'b0, 8'h00, 32'h0, 32'h0);
    check("irq clear", irq_o, 32'h0);
    $display("test qualify done");
    window_ok_i <= 1'b0;
    wait_n($urandom_range(300, 50));
    window_ok_i <= 1'b1;
    wait_n(20);
    check("ok held", power_ok_flag_o, 32'h1);
    window_ok_i <= 1'b0;
    rises(1'b0, n);
    check("fall count", n inside {[64:65]}, 32'h1);
    $display("test drop done");
    half <= 8'(20 + $urandom_range(20, 0));
    run <= 1'b1;
    wait_n(600);
    meas(n);
    check("sync half", n, half);
    run <= 1'b0;
    strap <= 1'b0;
    wait_n(300);
    meas(n);
    check("slow half", n, SH);
    wb(1'b0, 8'h00, 32'h0, 32'h6);
    $display("test clock done");
    window_ok_i <= 1'b1;
    shutdown_n_input_i <= 1'b0;
    wait_n(100);
    check("discharge", pins_o.softstart_node_oe, 32'h1);
    check("tristate", pins_o.switch_out_en, 32'h0);
    check("ok off", power_ok_flag_o, 32'h0);
    shutdown_n_input_i <= 1'b1;
    rises(1'b1, n);
    check("restart count", n inside {[64:66]}, 32'h1);
    $display("test shutdown done");
    print_verdict();
  end
  // hang guard
  initial
  begin
    #200000;
    err_total++;
    print_verdict();
  end
endmodule
